/* File: core/reset_remap_pkg.sv */
// Shared constants for the reset cause and memory remap block.
package reset_remap_pkg;
   localparam logic [31:0] ADDR_MAP_SELECT   = 32'hffff0220;
   localparam logic [31:0] ADDR_CAUSE_STATUS = 32'hffff0230;
   localparam logic [31:0] ADDR_CAUSE_CLEAR  = 32'hffff0234;
   localparam logic [31:0] ADDR_IRQ_STATUS   = 32'hffff0238;
   localparam logic [31:0] ADDR_IRQ_MASK     = 32'hffff023c;
   localparam int          MAP_SRAM_BIT      = 0;
   localparam int          CAUSE_POR_BIT     = 0;
   localparam int          CAUSE_WDT_BIT     = 1;
   localparam int          CAUSE_SW_BIT      = 2;
   localparam int          CAUSE_W           = 3;
   localparam logic [2:0]  CAUSE_POR_VAL     = 3'h1;
   localparam logic [2:0]  CAUSE_NONE        = 3'h0;
   localparam logic [7:0]  MAP_RESET_VAL     = 8'h00;
   localparam int          IRQ_CLR_BAD_BIT   = 2;
   localparam logic [31:0] VECTOR_ADDR       = 32'h00000000;
   localparam logic [31:0] VECTOR_TOP        = 32'h00000020;
   localparam int          CLK_PERIOD_PS     = 5000;
   localparam int          RST_PULSE_NS      = 100;
   localparam int          RST_PULSE_CYC     = (RST_PULSE_NS * 1000) / CLK_PERIOD_PS;
   localparam int          BOOT_TIME_NS      = 1000;
   localparam int          BOOT_CYC          = (BOOT_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
endpackage : reset_remap_pkg

/* File: core/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int         W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         ref_clk_i,
   input  wire logic         srst_i,
   input  wire logic [W-1:0] pin_i,
   output logic      [W-1:0] level_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   assign level_o = sync_q;
endmodule : pin_sync
`default_nettype wire

/* File: core/reset_stretch.sv */
// Stretches any reset trigger into a system reset of fixed minimum length.
`timescale 1ns/10ps
`default_nettype none
module reset_stretch #(
   parameter int CYC = 20
) (
   input  wire logic ref_clk_i,
   input  wire logic srst_i,
   input  wire logic trig_i,
   output logic      rst_o
);
   localparam int CW = $clog2(CYC + 1);
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;

   // A held trigger keeps reloading, so the pulse ends CYC cycles after it drops.
   assign cnt_d = trig_i ? CW'(CYC) : ((cnt_q != '0) ? cnt_q - CW'(1) : cnt_q);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cnt_q <= CW'(CYC);
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign rst_o = (cnt_q != '0);

   a_pulse_len : assert property (@(posedge ref_clk_i) disable iff (srst_i)
      $fell(trig_i) |-> rst_o [*2])
      else $error("Reset pulse ended too early.");
endmodule : reset_stretch
`default_nettype wire

/* File: core/reset_remap.sv */
// Reset cause log, SRAM/flash remap select and boot sequencing behind an Avalon-MM slave.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R1 - Any reset clears the map select so flash appears at address zero.
// R2 - Writing 1 to map select bit 0 mirrors SRAM at address zero.
// R3 - Clearing map select bit 0 brings flash back at address zero.
// R4 - The mirrored region covers at least the vectors from 0x0 to 0x20.
// R5 - Software switches the map only from flash above 0x00080020.
// R6 - After reset run the kernel, then in normal mode start at vector zero.
// R7 - Reset sources are external pin, power-on, watchdog and software.
// R8 - Power-on reset sets cause bit 0.
// R9 - Watchdog timeout sets cause bit 1.
// R10 - Writing 1 to cause bit 2 forces a reset and keeps that flag.
// R11 - A cause flag stays set until its clear register bit is written 1.
// R12 - External pin reset sets no cause flag.
// R13 - A clear leaving any set flag uncleared raises a reset.
// R14 - Cause bits 7 to 3 are reserved.
// R15 - Reserved bits read zero; the clear register reads zero.
module reset_remap #(
   parameter logic [31:0] MIRROR_TOP = reset_remap_pkg::VECTOR_TOP,
   parameter int          BOOT_CYC   = reset_remap_pkg::BOOT_CYC
) (
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic [31:0] avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        ext_rst_n_i,
   input  wire logic        wdt_timeout_i,
   input  wire logic        boot_select_n_i,
   input  wire logic [31:0] fetch_addr_i,
   output logic             fetch_sram_o,
   output logic             remap_sram_o,
   output logic             sys_rst_o,
   output logic             kernel_active_o,
   output logic             user_start_o,
   output logic      [31:0] start_addr_o,
   output logic             irq_o
);
   typedef enum logic [2:0] {
      BOOT_KERNEL   = 3'b001,
      BOOT_USER     = 3'b010,
      BOOT_DOWNLOAD = 3'b100
   } boot_state_t;

   localparam int BW = $clog2(BOOT_CYC + 1);

   function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
      return a == off;
   endfunction : hit

   logic        ack_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic [2:0]  cause_q;
   logic [2:0]  cause_d;
   logic        map_q;
   logic        map_d;
   logic [2:0]  ist_q;
   logic [2:0]  ist_d;
   logic [2:0]  msk_q;
   boot_state_t boot_q;
   boot_state_t boot_d;
   logic [BW-1:0] bcnt_q;
   logic        start_q;
   logic        start_d;
   logic [1:0]  pins_s;

   pin_sync #(
      .W       (2),
      .RST_VAL (2'h3)
   ) u_pin_sync (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .pin_i     ({ext_rst_n_i, boot_select_n_i}),
      .level_o   (pins_s)
   );

   wire ext_rst_n_s  = pins_s[1];
   wire boot_normal  = pins_s[0];

   // Avalon slave: one wait cycle per access, the transfer completes on the second edge.
   wire req       = avs_read_i | avs_write_i;
   wire done      = req & ack_q;
   wire wr        = done & avs_write_i & avs_byteenable_i[0];
   wire rd        = done & avs_read_i;
   wire hit_map   = hit(avs_address_i, reset_remap_pkg::ADDR_MAP_SELECT);
   wire hit_sta   = hit(avs_address_i, reset_remap_pkg::ADDR_CAUSE_STATUS);
   wire hit_clr   = hit(avs_address_i, reset_remap_pkg::ADDR_CAUSE_CLEAR);
   wire hit_ist   = hit(avs_address_i, reset_remap_pkg::ADDR_IRQ_STATUS);
   wire hit_msk   = hit(avs_address_i, reset_remap_pkg::ADDR_IRQ_MASK);
   wire [2:0] wd3 = avs_writedata_i[2:0];

   assign avs_waitrequest_o = req & ~ack_q;
   assign avs_readdata_o    = rdata_q;

   // Reset sources and cause flags.
   wire set_wdt   = wdt_timeout_i; // R9
   wire set_sw    = wr & hit_sta & wd3[reset_remap_pkg::CAUSE_SW_BIT]; // R10
   wire wr_clr    = wr & hit_clr;
   wire [2:0] clr_mask = wr_clr ? wd3 : reset_remap_pkg::CAUSE_NONE;
   wire clr_bad   = wr_clr & (|(cause_q & ~wd3)); // R13
   wire ext_rst   = ~ext_rst_n_s; // R12
   wire rst_trig  = set_wdt | set_sw | clr_bad | ext_rst; // R7
   wire rst_any   = rst_trig | sys_rst_o;

   // A new cause in the cycle of its clear wins over the clear.
   wire [2:0] cause_set = {set_sw, set_wdt, 1'b0};
   assign cause_d = (cause_q & ~clr_mask) | cause_set; // R11

   reset_stretch #(
      .CYC (reset_remap_pkg::RST_PULSE_CYC)
   ) u_reset_stretch (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .trig_i    (rst_trig),
      .rst_o     (sys_rst_o)
   );

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         cause_q <= reset_remap_pkg::CAUSE_POR_VAL; // R8
      end else begin
         cause_q <= cause_d; // R12
      end
   end

   // Map select; software must flip it from code outside the mirrored window.
   assign map_d = rst_any ? 1'b0 : ((wr & hit_map) ? avs_writedata_i[reset_remap_pkg::MAP_SRAM_BIT]
                                                   : map_q); // R1 R2 R3 R5

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         map_q <= reset_remap_pkg::MAP_RESET_VAL[0]; // R1
      end else begin
         map_q <= map_d;
      end
   end

   assign remap_sram_o = map_q;
   // The mirror decode covers the whole vector area; MIRROR_TOP sets its top and nothing stops a value below 0x20 from shrinking it.
   assign fetch_sram_o = map_q & (fetch_addr_i < MIRROR_TOP); // R4

   // Interrupt status: read clears, a concurrent event still sets.
   wire [2:0] ev = {clr_bad, set_sw, set_wdt};
   assign ist_d = ((rd & hit_ist) ? 3'h0 : ist_q) | ev;
   assign irq_o = |(ist_q & msk_q);

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ist_q <= 3'h0;
         msk_q <= 3'h0;
      end else begin
         ist_q <= ist_d;
         msk_q <= (wr & hit_msk) ? wd3 : msk_q;
      end
   end

   // Read data is latched in the wait cycle so it is steady when waitrequest drops.
   assign rdata_d = hit_map ? {31'h0, map_q} :
                    hit_sta ? {29'h0, cause_q} : // R14 R15
                    hit_ist ? {29'h0, ist_q} :
                    hit_msk ? {29'h0, msk_q} :
                    32'h0; // R15

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ack_q   <= req & ~ack_q;
         rdata_q <= (req & ~ack_q) ? rdata_d : rdata_q;
      end
   end

   // Boot sequencing: the kernel runs after every reset, then hands over.
   wire boot_done = (bcnt_q == '0);

   always_comb begin
      boot_d  = boot_q;
      start_d = 1'b0;
      unique case (boot_q)
         BOOT_KERNEL: begin
            if (boot_done) begin
               boot_d  = boot_normal ? BOOT_USER : BOOT_DOWNLOAD; // R6
               start_d = boot_normal;
            end
         end
         BOOT_USER: begin
            boot_d = BOOT_USER;
         end
         BOOT_DOWNLOAD: begin
            boot_d = BOOT_DOWNLOAD;
         end
      endcase
      if (rst_any) begin
         boot_d  = BOOT_KERNEL; // R6
         start_d = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         boot_q  <= BOOT_KERNEL;
         bcnt_q  <= BW'(BOOT_CYC);
         start_q <= 1'b0;
      end else begin
         boot_q  <= boot_d;
         bcnt_q  <= rst_any ? BW'(BOOT_CYC) : (boot_done ? bcnt_q : bcnt_q - BW'(1));
         start_q <= start_d;
      end
   end

   assign kernel_active_o = (boot_q == BOOT_KERNEL);
   assign user_start_o    = start_q;
   assign start_addr_o    = reset_remap_pkg::VECTOR_ADDR; // R6

   // Checks.
   a_map_reset : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R1
      rst_any |=> !remap_sram_o)
      else $error("Map select survived a reset.");
   a_map_set : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R2
      (wr && hit_map && avs_writedata_i[0] && !rst_any) |=> remap_sram_o)
      else $error("SRAM not mirrored after write.");
   a_map_clear : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R3
      (wr && hit_map && !avs_writedata_i[0]) |=> !remap_sram_o)
      else $error("Flash not restored after clear.");
   a_mirror_span : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R4
      (remap_sram_o && fetch_addr_i < 32'h20) |-> fetch_sram_o)
      else $error("Vector area not mirrored.");
   a_wdt_flag : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R9
      wdt_timeout_i |=> cause_q[1] && sys_rst_o)
      else $error("Watchdog cause not logged.");
   a_sw_reset : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R10
      set_sw |=> cause_q[2] && sys_rst_o && !remap_sram_o)
      else $error("Software reset not taken.");
   a_flag_hold : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R11
      !wr_clr |=> (cause_q & $past(cause_q)) == $past(cause_q))
      else $error("Cause flag lost without clear.");
   a_bad_clear : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R13
      clr_bad |=> sys_rst_o ##1 sys_rst_o)
      else $error("Partial clear raised no reset.");
   a_clr_reads_0 : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R15
      (rd && hit_clr) |-> avs_readdata_o == 32'h0)
      else $error("Clear register read nonzero.");
   a_boot_start : assert property (@(posedge ref_clk_i) disable iff (srst_i) // R6
      user_start_o |-> $past(kernel_active_o) && start_addr_o == 32'h0)
      else $error("User start not after kernel.");

   c_remap_sram : cover property (@(posedge ref_clk_i) disable iff (srst_i)
      wr && hit_map ##1 remap_sram_o);
   c_wdt_reset : cover property (@(posedge ref_clk_i) disable iff (srst_i)
      wdt_timeout_i ##1 sys_rst_o);
   c_bad_clear : cover property (@(posedge ref_clk_i) disable iff (srst_i) clr_bad);
   c_user_start : cover property (@(posedge ref_clk_i) disable iff (srst_i) user_start_o);
endmodule : reset_remap
`default_nettype wire

/* File: sim/cpu_model.sv */
// Bus master model of the processor core that owns the register bus.
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
   input  wire logic        ref_clk_i,
   output logic      [31:0] adr_o,
   output logic             rd_o,
   output logic             wr_o,
   output logic      [31:0] wdat_o,
   output logic      [3:0]  be_o,
   input  wire logic [31:0] rdat_i,
   input  wire logic        wait_i,
   output logic      [31:0] fetch_o
);
   initial begin
      adr_o = 32'h0;
      rd_o = 1'h0;
      wr_o = 1'h0;
      wdat_o = 32'h0;
      be_o = 4'hf;
      fetch_o = 32'h00080024;
   end
   // One transfer; the write data are inverted on release so nothing stale lingers.
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk_i);
      adr_o <= a;
      wdat_o <= d;
      rd_o <= !w;
      wr_o <= w;
      do @(posedge ref_clk_i); while (wait_i !== 1'h0);
      q = rdat_i;
      rd_o <= 1'h0;
      wr_o <= 1'h0;
      wdat_o <= ~d;
   endtask : xfer
   // Byte lanes apply to the next transfer; a write without lane 0 must be ignored.
   task set_be(input logic [3:0] b);
      @(posedge ref_clk_i);
      be_o <= b;
   endtask : set_be
   task set_fetch(input logic [31:0] a);
      @(posedge ref_clk_i);
      fetch_o <= a;
   endtask : set_fetch
   // The switch runs from flash above the mirror, never from the low window.
   task remap(input logic v);
      logic [31:0] q;
      set_fetch(32'h00080024);
      xfer(1'h1, reset_remap_pkg::ADDR_MAP_SELECT, {31'h0, v}, q);
   endtask : remap
endmodule : cpu_model
`default_nettype wire

/* File: sim/reset_remap_test.sv */
// Self-checking testbench for the reset cause and memory remap block.
`timescale 1ns/10ps
`default_nettype none
module reset_remap_test;
   logic        ref_clk = 1'h0;
   logic        srst    = 1'h1;
   logic        ext_n   = 1'h1;
   logic        wdt     = 1'h0;
   logic        boot_n  = 1'h1;
   logic [31:0] adr, wdat, rdat, fetch, saddr, q;
   logic [3:0]  be;
   logic        rd, wr, wrq, fsram, rsram, sysrst, kact, ustart, irq;
   int          mismatches = 0;
   int          compares   = 0;
   localparam logic [31:0] STA = reset_remap_pkg::ADDR_CAUSE_STATUS;
   localparam logic [31:0] CLR = reset_remap_pkg::ADDR_CAUSE_CLEAR;
   localparam logic [31:0] MAP = reset_remap_pkg::ADDR_MAP_SELECT;
   always #2.5 ref_clk = ~ref_clk;
   cpu_model i_cpu (.ref_clk_i(ref_clk), .adr_o(adr), .rd_o(rd), .wr_o(wr), .wdat_o(wdat),
      .be_o(be), .rdat_i(rdat), .wait_i(wrq), .fetch_o(fetch));
   reset_remap #(.BOOT_CYC(4)) i_dut (.ref_clk_i(ref_clk), .srst_i(srst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .ext_rst_n_i(ext_n),
      .wdt_timeout_i(wdt), .boot_select_n_i(boot_n), .fetch_addr_i(fetch),
      .fetch_sram_o(fsram), .remap_sram_o(rsram), .sys_rst_o(sysrst),
      .kernel_active_o(kact), .user_start_o(ustart), .start_addr_o(saddr), .irq_o(irq));
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, s, e);
      end
   endtask : chk
   task stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   task nap(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : nap
   task wrt(input logic [31:0] a, input logic [31:0] d);
      i_cpu.xfer(1'h1, a, d, q);
   endtask : wrt
   task rdc(input logic [31:0] a, input logic [31:0] e);
      i_cpu.xfer(1'h0, a, 32'h0, q);
      chk(q, e);
   endtask : rdc
   // The boot kernel runs after every reset, so the bus is left alone until the jump.
   task boot_wait;
      int n;
      n = 0;
      while (ustart !== 1'h1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk({31'h0, ustart}, 32'h1);
      chk({31'h0, kact}, 32'h0);
      chk(saddr, reset_remap_pkg::VECTOR_ADDR);
   endtask : boot_wait
   task t_por;
      boot_wait();
      rdc(STA, 32'h1);
      rdc(MAP, 32'h0);
      rdc(CLR, 32'h0);
      rdc(32'hffff0240, 32'h0);
      wrt(STA, 32'hf8);
      rdc(STA, 32'h1);
      wrt(CLR, 32'h1);
      rdc(STA, 32'h0);
      $display("power-on test done");
   endtask : t_por
   task t_remap;
      i_cpu.remap(1'h1);
      nap(1);
      chk({31'h0, rsram}, 32'h1);
      rdc(MAP, 32'h1);
      i_cpu.set_fetch(32'h0000001c);
      nap(1);
      chk({31'h0, fsram}, 32'h1);
      i_cpu.remap(1'h0);
      nap(1);
      chk({31'h0, rsram}, 32'h0);
      i_cpu.set_be(4'he);
      wrt(MAP, 32'h1);
      rdc(MAP, 32'h0);
      i_cpu.set_be(4'hf);
      $display("remap test done");
   endtask : t_remap
   task t_wdt;
      i_cpu.remap(1'h1);
      wrt(reset_remap_pkg::ADDR_IRQ_MASK, 32'h1);
      chk({31'h0, irq}, 32'h0);
      @(posedge ref_clk);
      wdt <= 1'h1;
      @(posedge ref_clk);
      wdt <= 1'h0;
      nap(2);
      chk({31'h0, sysrst}, 32'h1);
      chk({31'h0, rsram}, 32'h0);
      boot_wait();
      rdc(STA, 32'h2);
      chk({31'h0, irq}, 32'h1);
      rdc(reset_remap_pkg::ADDR_IRQ_STATUS, 32'h1);
      nap(1);
      chk({31'h0, irq}, 32'h0);
      wrt(CLR, 32'h2);
      rdc(STA, 32'h0);
      $display("watchdog test done");
   endtask : t_wdt
   task t_sw;
      wrt(STA, 32'h4);
      nap(2);
      chk({31'h0, sysrst}, 32'h1);
      boot_wait();
      rdc(STA, 32'h4);
      wrt(CLR, 32'h1);
      nap(2);
      chk({31'h0, sysrst}, 32'h1);
      boot_wait();
      rdc(STA, 32'h4);
      wrt(CLR, 32'h4);
      nap(2);
      chk({31'h0, sysrst}, 32'h0);
      rdc(STA, 32'h0);
      rdc(reset_remap_pkg::ADDR_IRQ_STATUS, 32'h6);
      $display("software reset test done");
   endtask : t_sw
   // Boot select low: after the kernel the block enters download mode with kernel_active_o low and never jumps to the user vector.
   task t_dl;
      int n;
      @(posedge ref_clk);
      boot_n <= 1'h0;
      wdt    <= 1'h1;
      @(posedge ref_clk);
      wdt <= 1'h0;
      nap(2);
      chk({31'h0, kact}, 32'h1);
      n = 0;
      repeat (60) begin
         @(posedge ref_clk);
         if (ustart !== 1'h0) begin
            n++;
         end
      end
      chk(n, 32'h0);
      chk({31'h0, kact}, 32'h0);
      rdc(STA, 32'h2);
      rdc(reset_remap_pkg::ADDR_IRQ_STATUS, 32'h1);
      wrt(CLR, 32'h2);
      rdc(STA, 32'h0);
      boot_n <= 1'h1;
      $display("download mode test done");
   endtask : t_dl
   task t_ext;
      i_cpu.remap(1'h1);
      @(posedge ref_clk);
      ext_n <= 1'h0;
      nap(6);
      chk({31'h0, sysrst}, 32'h1);
      chk({31'h0, rsram}, 32'h0);
      ext_n <= 1'h1;
      nap(4);
      boot_wait();
      rdc(STA, 32'h0);
      $display("external reset test done");
   endtask : t_ext
   initial begin
      nap(10);
      srst <= 1'h0;
      t_por();
      t_remap();
      t_wdt();
      t_sw();
      t_ext();
      t_dl();
      stop_test();
   end
   initial begin
      nap(20000);
      mismatches++;
      stop_test();
   end
endmodule : reset_remap_test
`default_nettype wire
